// ### coll_page_mode_pkg.sv
// Shared constants and carriers for the collision, page and mode register slice.
// Assumes an 8-bit register port with a 6-bit register address.
package coll_page_mode_pkg;

  // Register address width and data width
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [5:0] OFF_COLLISION_REPORT = 6'h0e;
  localparam logic [5:0] OFF_REGISTER_PAGE_SELECT = 6'h10;
  localparam logic [5:0] OFF_GENERAL_MODE_SETTINGS = 6'h11;

  // Values after reset
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h3b;
  localparam logic RST_KEEP_VALUES = 1'b1;
  localparam logic RST_COLL_INVALID = 1'b1;
  localparam logic [4:0] RST_COLL_POS = 5'h00;

  // Collision report field positions
  localparam int COLL_KEEP_BIT = 7;
  localparam int COLL_INVALID_BIT = 5;
  localparam int COLL_POS_MSB = 4;

  // Page register field positions
  localparam int PAGE_OVERRIDE_BIT = 7;
  localparam int PAGE_FIELD_MSB = 1;

  // Mode register field positions
  localparam int MODE_CRC_ORDER_BIT = 7;
  localparam int MODE_SYNC_DETECT_BIT = 6;
  localparam int MODE_TX_WAIT_BIT = 5;
  localparam int MODE_RX_WAIT_BIT = 4;
  localparam int MODE_SIG_POL_BIT = 3;

  // Sync byte for the contactless serial unit
  localparam logic [7:0] SYNC_BYTE = 8'hf0;

  // Highest collision position that the 5-bit field can express
  localparam logic [5:0] COLL_POS_LIMIT = 6'h20;

  // Register port request
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Receive bit events seen by the collision tracker
  typedef struct packed {
    logic frame_start;
    logic data_bit;
    logic collision;
  } rx_bit_evt_s;

endpackage : coll_page_mode_pkg

// ### coll_tracker.sv
// Tracks the first collision in a received frame and its position.
// Assumes bit events come from receiver logic on the same clock.
`timescale 1ns/1ns
module coll_tracker
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire coll_page_mode_pkg::rx_bit_evt_s evt_i,
  input wire logic keep_values_i,
  output logic [4:0] coll_pos_o,
  output logic coll_invalid_o,
  output logic discard_o
);

  // Count of data bits already received in the frame, saturating
  logic [5:0] bit_cnt_reg;
  logic [5:0] bit_cnt_next;
  // Set once the first collision of the frame has been seen
  logic seen_reg;
  // Position of the colliding bit, counted from one
  logic [5:0] hit_pos;
  // First collision of this frame happens now
  logic first_hit;
  // Colliding position fits the field
  logic in_range;

  assign hit_pos = bit_cnt_reg + 6'h01;
  assign first_hit = evt_i.data_bit & evt_i.collision & ~seen_reg & ~evt_i.frame_start;
  assign in_range = (hit_pos <= coll_page_mode_pkg::COLL_POS_LIMIT);
  assign bit_cnt_next = (bit_cnt_reg == 6'h3f) ? bit_cnt_reg : hit_pos;

  // Bit counter and collision capture
  always_ff @(posedge clk_i)
  begin
    if (srst_i || evt_i.frame_start)
    begin
      // New frame: nothing seen yet, position reported invalid
      bit_cnt_reg <= 6'h00;
      seen_reg <= 1'b0;
      coll_pos_o <= coll_page_mode_pkg::RST_COLL_POS;
      coll_invalid_o <= coll_page_mode_pkg::RST_COLL_INVALID;
      discard_o <= 1'b0;
    end
    else
    begin
      if (evt_i.data_bit)
      begin
        bit_cnt_reg <= bit_cnt_next;
      end
      if (first_hit)
      begin
        seen_reg <= 1'b1;
        // Position 32 wraps to zero in five bits
        coll_pos_o <= hit_pos[4:0];
        coll_invalid_o <= ~in_range;
        // Later bits are dropped unless software keeps them
        discard_o <= ~keep_values_i;
      end
    end
  end

  // Collision in range clears the invalid flag one cycle later
  property p_coll_valid;
    @(posedge clk_i) disable iff (srst_i)
      (first_hit && in_range) |=> !coll_invalid_o;
  endproperty
  a_coll_valid: assert property (p_coll_valid) else $error("invalid flag not cleared");

  // Out of range collision leaves the flag set
  property p_coll_range;
    @(posedge clk_i) disable iff (srst_i)
      (first_hit && !in_range) |=> coll_invalid_o;
  endproperty
  a_coll_range: assert property (p_coll_range) else $error("out of range not flagged");

  // Reported position equals the count of bits up to the collision
  property p_coll_pos;
    @(posedge clk_i) disable iff (srst_i)
      first_hit |=> (coll_pos_o == $past(hit_pos[4:0]));
  endproperty
  a_coll_pos: assert property (p_coll_pos) else $error("collision position wrong");

  // Discard follows the keep bit after the first collision
  property p_discard;
    @(posedge clk_i) disable iff (srst_i)
      (first_hit && !keep_values_i) |=> discard_o;
  endproperty
  a_discard: assert property (p_discard) else $error("bits not discarded");

endmodule : coll_tracker

// ### coll_page_mode_regs.sv
// Collision report, page select and general mode registers.
// Assumes a host register port on clk_i and receiver/CRC logic on the same clock.
// Function
// - Keep bit zero clears bits after collision
// - Invalid flag when none or out of range
// - Five-bit position of first collision, data bits
// - 01h first bit, 00h thirty-second bit
// - Override on: page field gives A5 A4
// - Override off: latch alone gives address
// - Page field used only under override
// - Msb-first CRC, result bytes bit reversed
// - CRC order ignored during RF communication
// - Sync detect waits for and prepends F0h
// - Transmit waits for own RF field
// - Receive-wait counter waits for external field
// - Signal input polarity follows polarity bit
// - Polarity change raises signal activity event
`timescale 1ns/1ns
module coll_page_mode_regs
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire coll_page_mode_pkg::reg_req_s bus_i,
  output logic [7:0] rdata_o,
  output logic [5:0] eff_addr_o,
  input wire coll_page_mode_pkg::rx_bit_evt_s rx_evt_i,
  output logic [4:0] coll_pos_o,
  output logic coll_invalid_o,
  output logic discard_rx_bits_o,
  input wire logic rf_comm_active_i,
  input wire logic [15:0] crc_result_i,
  output logic [15:0] crc_result_o,
  output logic crc_msb_first_o,
  input wire logic rx_on_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_enable_o,
  output logic tx_sync_prefix_o,
  output logic [7:0] sync_byte_o,
  input wire logic reader_mode_i,
  input wire logic own_field_on_i,
  input wire logic tx_start_req_i,
  output logic tx_go_o,
  input wire logic target_mode_i,
  input wire logic ext_field_i,
  input wire logic rx_wait_req_i,
  output logic rx_wait_go_o,
  input wire logic secure_element_signal_input_i,
  output logic se_input_active_o,
  output logic signal_input_activity_event_o
);

  // Stored page register: override bit and page field
  logic page_override_enable_reg;
  logic [1:0] page_field_reg;
  // Stored mode register
  logic [7:0] mode_reg;
  // Stored keep-values bit of the collision report
  logic keep_values_after_collision_reg;
  // Collision tracker outputs
  logic [4:0] coll_pos;
  logic coll_invalid;
  logic discard;

  // Effective register address under page override
  logic [5:0] eff_addr;
  assign eff_addr = page_override_enable_reg ? {page_field_reg, bus_i.addr[3:0]} : bus_i.addr;

  // Register decode on the effective address
  logic hit_coll;
  logic hit_page;
  logic hit_mode;
  assign hit_coll = (eff_addr == coll_page_mode_pkg::OFF_COLLISION_REPORT);
  assign hit_page = (eff_addr == coll_page_mode_pkg::OFF_REGISTER_PAGE_SELECT);
  assign hit_mode = (eff_addr == coll_page_mode_pkg::OFF_GENERAL_MODE_SETTINGS);

  // Write strobes per register
  logic wr_coll;
  logic wr_page;
  logic wr_mode;
  assign wr_coll = bus_i.wr & hit_coll;
  assign wr_page = bus_i.wr & hit_page;
  assign wr_mode = bus_i.wr & hit_mode;

  // Read views, reserved bits at zero
  logic [7:0] coll_view;
  logic [7:0] page_view;
  logic [7:0] read_mux;
  assign coll_view = {keep_values_after_collision_reg, 1'b0, coll_invalid, coll_pos};
  assign page_view = {page_override_enable_reg, 5'h00, page_field_reg};
  assign read_mux = hit_coll ? coll_view :
                    hit_page ? page_view :
                    hit_mode ? mode_reg : 8'h00;

  // Polarity bit changes on this write
  logic pol_change;
  assign pol_change = wr_mode &
    (bus_i.wdata[coll_page_mode_pkg::MODE_SIG_POL_BIT] != mode_reg[coll_page_mode_pkg::MODE_SIG_POL_BIT]);

  // Mode fields
  logic crc_order;
  logic sync_detect;
  logic tx_wait_field;
  logic rx_wait_field;
  logic sig_pol;
  assign crc_order = mode_reg[coll_page_mode_pkg::MODE_CRC_ORDER_BIT];
  assign sync_detect = mode_reg[coll_page_mode_pkg::MODE_SYNC_DETECT_BIT];
  assign tx_wait_field = mode_reg[coll_page_mode_pkg::MODE_TX_WAIT_BIT];
  assign rx_wait_field = mode_reg[coll_page_mode_pkg::MODE_RX_WAIT_BIT];
  assign sig_pol = mode_reg[coll_page_mode_pkg::MODE_SIG_POL_BIT];

  // Reverses the bit order of one byte
  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction : rev8

  // Msb-first order only for standalone CRC work
  logic crc_msb_eff;
  assign crc_msb_eff = crc_order & ~rf_comm_active_i;

  // Pin synchronisers for external field and signal input
  logic field_s1_reg;
  logic field_s2_reg;
  logic field_s3_reg;
  logic field_lvl_reg;
  logic sig_s1_reg;
  logic sig_s2_reg;
  logic sig_s3_reg;
  logic sig_lvl_reg;

  // Transmit and receive-wait pending requests
  logic tx_pend_reg;
  logic rx_wait_pend_reg;
  logic tx_ok;
  logic rx_wait_ok;
  logic tx_fire;
  logic rx_wait_fire;
  assign tx_ok = ~tx_wait_field | ~reader_mode_i | own_field_on_i;
  assign rx_wait_ok = ~rx_wait_field | ~target_mode_i | field_lvl_reg;
  assign tx_fire = tx_pend_reg & tx_ok;
  assign rx_wait_fire = rx_wait_pend_reg & rx_wait_ok;

  // Sync hunt state: receiver held off until sync byte
  logic hunt_reg;
  logic sync_seen;
  assign sync_seen = rx_byte_valid_i & (rx_byte_i == coll_page_mode_pkg::SYNC_BYTE);

  // Collision position tracking
  coll_tracker u_coll_tracker
  (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .evt_i(rx_evt_i),
    .keep_values_i(keep_values_after_collision_reg),
    .coll_pos_o(coll_pos),
    .coll_invalid_o(coll_invalid),
    .discard_o(discard)
  );

  // Software registers
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      page_override_enable_reg <= coll_page_mode_pkg::RST_PAGE[coll_page_mode_pkg::PAGE_OVERRIDE_BIT];
      page_field_reg <= coll_page_mode_pkg::RST_PAGE[coll_page_mode_pkg::PAGE_FIELD_MSB:0];
      mode_reg <= coll_page_mode_pkg::RST_MODE;
      keep_values_after_collision_reg <= coll_page_mode_pkg::RST_KEEP_VALUES;
    end
    else
    begin
      if (wr_page)
      begin
        // Only bit 7 and bits 1:0 are stored
        page_override_enable_reg <= bus_i.wdata[coll_page_mode_pkg::PAGE_OVERRIDE_BIT];
        page_field_reg <= bus_i.wdata[coll_page_mode_pkg::PAGE_FIELD_MSB:0];
      end
      if (wr_mode)
      begin
        mode_reg <= bus_i.wdata;
      end
      if (wr_coll)
      begin
        // Status bits of the collision report are read only
        keep_values_after_collision_reg <= bus_i.wdata[coll_page_mode_pkg::COLL_KEEP_BIT];
      end
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rdata_o <= 8'h00;
    end
    else
    begin
      rdata_o <= bus_i.rd ? read_mux : 8'h00;
    end
  end

  // Three-stage pin synchronisers with agreement filter
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      field_s1_reg <= 1'b0;
      field_s2_reg <= 1'b0;
      field_s3_reg <= 1'b0;
      field_lvl_reg <= 1'b0;
      sig_s1_reg <= 1'b0;
      sig_s2_reg <= 1'b0;
      sig_s3_reg <= 1'b0;
      sig_lvl_reg <= 1'b0;
    end
    else
    begin
      field_s1_reg <= ext_field_i;
      field_s2_reg <= field_s1_reg;
      field_s3_reg <= field_s2_reg;
      sig_s1_reg <= secure_element_signal_input_i;
      sig_s2_reg <= sig_s1_reg;
      sig_s3_reg <= sig_s2_reg;
      // A change counts once stages two and three agree
      if (field_s2_reg == field_s3_reg)
      begin
        field_lvl_reg <= field_s3_reg;
      end
      if (sig_s2_reg == sig_s3_reg)
      begin
        sig_lvl_reg <= sig_s3_reg;
      end
    end
  end

  // Pending start requests; a new request wins over the firing clear
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tx_pend_reg <= 1'b0;
      rx_wait_pend_reg <= 1'b0;
      hunt_reg <= 1'b0;
    end
    else
    begin
      tx_pend_reg <= (tx_pend_reg & ~tx_fire) | tx_start_req_i;
      rx_wait_pend_reg <= (rx_wait_pend_reg & ~rx_wait_fire) | rx_wait_req_i;
      // Arm sync hunt while receiver is off and sync detect is on; sync byte ends it once on
      if (!rx_on_i)
      begin
        hunt_reg <= sync_detect;
      end
      else if (sync_seen)
      begin
        hunt_reg <= 1'b0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      eff_addr_o <= 6'h00;
      coll_pos_o <= coll_page_mode_pkg::RST_COLL_POS;
      coll_invalid_o <= coll_page_mode_pkg::RST_COLL_INVALID;
      discard_rx_bits_o <= 1'b0;
      crc_result_o <= 16'h0000;
      crc_msb_first_o <= 1'b0;
      rx_enable_o <= 1'b0;
      tx_sync_prefix_o <= 1'b0;
      sync_byte_o <= coll_page_mode_pkg::SYNC_BYTE;
      tx_go_o <= 1'b0;
      rx_wait_go_o <= 1'b0;
      se_input_active_o <= 1'b0;
      signal_input_activity_event_o <= 1'b0;
    end
    else
    begin
      eff_addr_o <= eff_addr;
      coll_pos_o <= coll_pos;
      coll_invalid_o <= coll_invalid;
      discard_rx_bits_o <= discard;
      crc_msb_first_o <= crc_msb_eff;
      crc_result_o <= crc_msb_eff ? {rev8(crc_result_i[15:8]), rev8(crc_result_i[7:0])} : crc_result_i;
      rx_enable_o <= rx_on_i & ~hunt_reg & ~(sync_detect & ~rx_on_i);
      tx_sync_prefix_o <= sync_detect;
      sync_byte_o <= coll_page_mode_pkg::SYNC_BYTE;
      tx_go_o <= tx_fire;
      rx_wait_go_o <= rx_wait_fire;
      se_input_active_o <= sig_pol ? sig_lvl_reg : ~sig_lvl_reg;
      signal_input_activity_event_o <= pol_change;
    end
  end

  // Override places the page field in the top address bits
  property p_page_addr;
    @(posedge clk_i) disable iff (srst_i)
      page_override_enable_reg |=> (eff_addr_o == {$past(page_field_reg), $past(bus_i.addr[3:0])});
  endproperty
  a_page_addr: assert property (p_page_addr) else $error("page override address wrong");

  // Without override the address passes unchanged
  property p_page_off;
    @(posedge clk_i) disable iff (srst_i)
      !page_override_enable_reg |=> (eff_addr_o == $past(bus_i.addr));
  endproperty
  a_page_off: assert property (p_page_off) else $error("latch address altered");

  // Msb-first reporting is off during RF communication
  property p_crc_order;
    @(posedge clk_i) disable iff (srst_i)
      rf_comm_active_i |=> !crc_msb_first_o;
  endproperty
  a_crc_order: assert property (p_crc_order) else $error("crc order used during RF");

  // Reversed low result byte when msb-first applies
  property p_crc_rev;
    @(posedge clk_i) disable iff (srst_i)
      crc_msb_eff |=> (crc_result_o[7:0] == rev8($past(crc_result_i[7:0])));
  endproperty
  a_crc_rev: assert property (p_crc_rev) else $error("crc byte not reversed");

  // Transmitter never fires while waiting for own field
  property p_tx_wait;
    @(posedge clk_i) disable iff (srst_i)
      (tx_wait_field && reader_mode_i && !own_field_on_i) |=> !tx_go_o;
  endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("transmit started without field");

  // Receive-wait counter held until external field seen
  property p_rx_wait;
    @(posedge clk_i) disable iff (srst_i)
      (rx_wait_field && target_mode_i && !field_lvl_reg) |=> !rx_wait_go_o;
  endproperty
  a_rx_wait: assert property (p_rx_wait) else $error("receive wait started without field");

  // Polarity maps the filtered level onto the active output
  property p_se_pol;
    @(posedge clk_i) disable iff (srst_i)
      1'b1 |=> (se_input_active_o == ($past(sig_pol) ? $past(sig_lvl_reg) : !$past(sig_lvl_reg)));
  endproperty
  a_se_pol: assert property (p_se_pol) else $error("signal polarity wrong");

  // Polarity change yields a single event pulse
  sequence s_pol_write;
    pol_change;
  endsequence
  property p_se_evt;
    @(posedge clk_i) disable iff (srst_i)
      s_pol_write |=> signal_input_activity_event_o ##1 (!signal_input_activity_event_o || $past(pol_change));
  endproperty
  a_se_evt: assert property (p_se_evt) else $error("no signal activity event");

  // Reserved page bits always read zero
  property p_rsvd;
    @(posedge clk_i) disable iff (srst_i)
      (bus_i.rd && hit_page) |=> (rdata_o[6:2] == 5'h00);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  // Receiver stays off while hunting for sync
  property p_sync;
    @(posedge clk_i) disable iff (srst_i)
      hunt_reg |=> !rx_enable_o;
  endproperty
  a_sync: assert property (p_sync) else $error("receiver on before sync");

endmodule : coll_page_mode_regs

// ### rf_frame_model.sv
// Model of the receive side: sends one frame of data-bit events to the slice.
// Assumes the slice clock; start_i is a one-cycle pulse and the frame runs to the end.
`timescale 1ns/1ns
module rf_frame_model
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [5:0] nbits_i,
  input wire logic [5:0] coll_at_i,
  input wire logic slow_i,
  output coll_page_mode_pkg::rx_bit_evt_s evt_o,
  output logic busy_o
);
  logic [5:0] sent_reg; // Data bits sent so far
  logic gap_reg; // Idle cycle before the next bit
  logic [5:0] sent_next; // Count after this bit

  assign sent_next = sent_reg + 6'h01;

  // Frame start first, then data bits, with the collision flag on one bit
  always_ff @(posedge clk_i)
  begin
    evt_o <= '0;
    if (srst_i)
    begin
      busy_o <= 1'b0;
      sent_reg <= 6'h00;
      gap_reg <= 1'b0;
    end
    else if (start_i)
    begin
      evt_o.frame_start <= 1'b1;
      busy_o <= 1'b1;
      sent_reg <= 6'h00;
      gap_reg <= 1'b1;
    end
    else if (busy_o && gap_reg)
      gap_reg <= 1'b0; // Slow mode idles between bits
    else if (busy_o)
    begin
      evt_o.data_bit <= 1'b1;
      evt_o.collision <= (sent_next == coll_at_i);
      sent_reg <= sent_next;
      gap_reg <= slow_i;
      busy_o <= (sent_next != nbits_i);
    end
  end
endmodule : rf_frame_model

// ### tb_top.sv
// Self-checking bench for the collision, page and mode register slice.
// Assumes a 10 MHz clock; the bench plays host and drives every side input.
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  coll_page_mode_pkg::reg_req_s bus_i = '0; // Host register port
  coll_page_mode_pkg::rx_bit_evt_s rx_evt_i; // From the frame model
  logic [7:0] rdata_o, sync_byte_o, rx_byte_i = 8'h00;
  logic [5:0] eff_addr_o, nbits = 6'h00, coll_at = 6'h00;
  logic [4:0] coll_pos_o;
  logic [15:0] crc_result_i = 16'h0000, crc_result_o;
  logic coll_invalid_o, discard_rx_bits_o, crc_msb_first_o, rx_enable_o, tx_sync_prefix_o;
  logic tx_go_o, rx_wait_go_o, se_input_active_o, signal_input_activity_event_o, busy;
  logic rf_comm_active_i = 1'b0, rx_on_i = 1'b0, rx_byte_valid_i = 1'b0, reader_mode_i = 1'b0;
  logic own_field_on_i = 1'b0, tx_start_req_i = 1'b0, target_mode_i = 1'b0, ext_field_i = 1'b0;
  logic rx_wait_req_i = 1'b0, secure_element_signal_input_i = 1'b0, start = 1'b0, slow = 1'b0;
  int errors = 0, checks = 0, cycles = 0, txgo_n = 0, rwgo_n = 0, evt_n = 0;
  logic [5:0] coll_tab [5] = '{6'h01, 6'h08, 6'h20, 6'h21, 6'h00}; // Collision bit
  logic [7:0] coll_exp [5] = '{8'h81, 8'h88, 8'h80, 8'ha1, 8'ha0}; // Report value

  coll_page_mode_regs i_dut (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .eff_addr_o(eff_addr_o), .rx_evt_i(rx_evt_i), .coll_pos_o(coll_pos_o), .coll_invalid_o(coll_invalid_o),
    .discard_rx_bits_o(discard_rx_bits_o), .rf_comm_active_i(rf_comm_active_i), .crc_result_i(crc_result_i),
    .crc_result_o(crc_result_o), .crc_msb_first_o(crc_msb_first_o), .rx_on_i(rx_on_i),
    .rx_byte_valid_i(rx_byte_valid_i), .rx_byte_i(rx_byte_i), .rx_enable_o(rx_enable_o),
    .tx_sync_prefix_o(tx_sync_prefix_o), .sync_byte_o(sync_byte_o), .reader_mode_i(reader_mode_i),
    .own_field_on_i(own_field_on_i), .tx_start_req_i(tx_start_req_i), .tx_go_o(tx_go_o),
    .target_mode_i(target_mode_i), .ext_field_i(ext_field_i), .rx_wait_req_i(rx_wait_req_i),
    .rx_wait_go_o(rx_wait_go_o), .secure_element_signal_input_i(secure_element_signal_input_i),
    .se_input_active_o(se_input_active_o), .signal_input_activity_event_o(signal_input_activity_event_o));

  rf_frame_model i_rf (.clk_i(clk_i), .srst_i(srst_i), .start_i(start), .nbits_i(nbits),
    .coll_at_i(coll_at), .slow_i(slow), .evt_o(rx_evt_i), .busy_o(busy));

  // Clock: 100 ns period
  always #50 clk_i = ~clk_i;

  // Pulse counters and hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (tx_go_o === 1'b1) txgo_n++;
    if (rx_wait_go_o === 1'b1) rwgo_n++;
    if (signal_input_activity_event_o === 1'b1) evt_n++;
    if (cycles == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  // Compare one value, count it, report a mismatch
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle register write
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_i <= '0;
  endtask : wr

  // One-cycle read; data and effective address checked in the next cycle
  task automatic rdc(input logic [5:0] a, input logic [7:0] d, input logic [5:0] e);
    @(posedge clk_i);
    bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_i <= '0;
    #1;
    chk(16'(rdata_o), 16'(d));
    chk(16'(eff_addr_o), 16'(e));
  endtask : rdc

  // Wait whole cycles, then settle
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : w

  // Send one frame and wait until the report has landed
  task automatic frame(input logic [5:0] n, input logic [5:0] c, input logic s);
    int i;
    @(posedge clk_i);
    start <= 1'b1;
    nbits <= n;
    coll_at <= c;
    slow <= s;
    @(posedge clk_i);
    start <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk_i);
    w(4);
  endtask : frame

  // One received byte pulse
  task automatic byte_in(input logic [7:0] b);
    @(posedge clk_i);
    rx_byte_valid_i <= 1'b1;
    rx_byte_i <= b;
    @(posedge clk_i);
    rx_byte_valid_i <= 1'b0;
    w(3);
  endtask : byte_in

  // Final counts and verdict
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    rdc(6'h10, 8'h00, 6'h10);
    rdc(6'h11, 8'h3b, 6'h11);
    rdc(6'h0e, 8'ha0, 6'h0e);
    chk(16'(sync_byte_o), 16'h00f0);
    wr(6'h10, 8'h7c);
    rdc(6'h10, 8'h00, 6'h10);
    wr(6'h0e, 8'h7f);
    rdc(6'h0e, 8'h20, 6'h0e);
    wr(6'h0e, 8'h80);
    rdc(6'h3f, 8'h00, 6'h3f);
    $display("done: reset and access");
    wr(6'h10, 8'h81);
    rdc(6'h21, 8'h3b, 6'h11);
    wr(6'h30, 8'h02);
    rdc(6'h21, 8'h00, 6'h21);
    rdc(6'h11, 8'h3b, 6'h11);
    wr(6'h10, 8'h00);
    $display("done: page override");
    for (int k = 0; k < 5; k++)
    begin
      frame(6'h28, coll_tab[k], k[0]);
      chk(16'(coll_invalid_o), 16'(coll_exp[k][5]));
      chk(16'(coll_pos_o), 16'(coll_exp[k][4:0]));
      rdc(6'h0e, coll_exp[k], 6'h0e);
      chk(16'(discard_rx_bits_o), 16'h0000);
    end
    wr(6'h0e, 8'h00);
    frame(6'h14, 6'h03, 1'b0);
    chk(16'(discard_rx_bits_o), 16'h0001);
    rdc(6'h0e, 8'h03, 6'h0e);
    frame(6'h14, 6'h00, 1'b1);
    chk(16'(discard_rx_bits_o), 16'h0000);
    wr(6'h0e, 8'h80);
    $display("done: collision");
    wr(6'h11, 8'hbb);
    @(posedge clk_i);
    crc_result_i <= 16'h0183;
    w(3);
    chk(crc_result_o, 16'h80c1);
    chk(16'(crc_msb_first_o), 16'h0001);
    rf_comm_active_i <= 1'b1;
    w(3);
    chk(crc_result_o, 16'h0183);
    chk(16'(crc_msb_first_o), 16'h0000);
    rf_comm_active_i <= 1'b0;
    wr(6'h11, 8'h3b);
    $display("done: crc order");
    wr(6'h11, 8'h7b);
    w(3);
    chk(16'(tx_sync_prefix_o), 16'h0001);
    rx_on_i <= 1'b1;
    w(3);
    chk(16'(rx_enable_o), 16'h0000);
    byte_in(8'h55);
    chk(16'(rx_enable_o), 16'h0000);
    byte_in(8'hf0);
    chk(16'(rx_enable_o), 16'h0001);
    rx_on_i <= 1'b0;
    wr(6'h11, 8'h3b);
    $display("done: sync detect");
    reader_mode_i <= 1'b1;
    tx_start_req_i <= 1'b1;
    @(posedge clk_i);
    tx_start_req_i <= 1'b0;
    w(8);
    chk(16'(txgo_n), 16'h0000);
    own_field_on_i <= 1'b1;
    w(4);
    chk(16'(txgo_n), 16'h0001);
    target_mode_i <= 1'b1;
    rx_wait_req_i <= 1'b1;
    @(posedge clk_i);
    rx_wait_req_i <= 1'b0;
    w(12);
    chk(16'(rwgo_n), 16'h0000);
    ext_field_i <= 1'b1;
    w(12);
    chk(16'(rwgo_n), 16'h0001);
    $display("done: field waits");
    secure_element_signal_input_i <= 1'b1;
    w(10);
    chk(16'(se_input_active_o), 16'h0001);
    chk(16'(evt_n), 16'h0000);
    wr(6'h11, 8'h33);
    w(10);
    chk(16'(evt_n), 16'h0001);
    chk(16'(se_input_active_o), 16'h0000);
    wr(6'h11, 8'h33);
    w(4);
    chk(16'(evt_n), 16'h0001);
    own_field_on_i <= 1'b0;
    wr(6'h11, 8'h03);
    tx_start_req_i <= 1'b1;
    @(posedge clk_i);
    tx_start_req_i <= 1'b0;
    w(4);
    chk(16'(txgo_n), 16'h0002);
    chk(16'(evt_n), 16'h0001);
    $display("done: signal input");
    tally_and_finish();
  end
endmodule : tb_top
